/* File: design/tpc_top.sv */
// APB timer/counter pair: 8-bit and 16-bit with pulse width measurement
//
// Overview of operation
// - in pulse mode setting the run bit only arms; an edge starts counting
// - edge select low: falling edge starts, return high stops and clears run
// - edge select high: rising edge starts, return low stops and clears run
// - hardware clears the run bit only in pulse mode
// - pulse mode counts system clock over four while the pulse is active
// - once run is cleared pin changes are ignored; count stays readable
// - overflow in pulse mode signals, reloads from preload, keeps counting
// - timer interrupt output is suppressed while its enable is zero
// - pin is a timer input only in event or pulse mode with port input set
// - pull-high option stays in force while the pin is a timer input
// - pin changes are recognised only at the next timer tick
// - counter clock inhibited during counter reads and preload writes
// - every overflow sets the request flag; interrupt only when enabled
// - overflow wakes from power-down regardless of enables, unless its flag is already set
// - mode in bits 7 and 6, run in bit 4, edge select in bit 3
// - 8-bit overflows after FFH, 16-bit after FFFFH, both reload
// - preload write when stopped loads counter; when running waits overflow
// - 16-bit low write buffered until high write; high read latches low
`timescale 1ns/1ps
`default_nettype none
module tpc_top
  import tpc_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [REG_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // timer pins
  input  wire logic              counter0_input_pin,
  input  wire logic              counter1_input_pin,
  input  wire logic [1:0]        pullup_option,
  output logic      [1:0]        pullup_en,
  // system
  input  wire logic              power_down,
  output logic                   timer_irq0,
  output logic                   timer_irq1,
  output logic                   wake_pulse
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [REG_AW-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic pin_is_timer(input logic [1:0] m, input logic port_in);
    pin_is_timer = port_in && (m == MODE_EVENT || m == MODE_PULSE);
  endfunction

  logic [1:0]  s1_q;
  logic [1:0]  s2_q;
  logic [1:0]  s3_q;
  logic [1:0]  lvl_q;
  logic [TICK_W-1:0] div_q;
  logic        tick_q;
  logic [7:0]  ctrl0_q;
  logic [7:0]  ctrl1_q;
  logic        ie0_q;
  logic        ie1_q;
  logic        flag0_q;
  logic        flag1_q;
  logic [1:0]  port_in_q;
  logic [7:0]  lo_wbuf_q;
  logic [7:0]  lo_rbuf_q;
  logic [7:0]  count0;
  logic [15:0] count1;
  logic        clr0;
  logic        clr1;
  logic        ovf0;
  logic        ovf1;
  logic        access;
  logic        commit;
  logic        wr;
  logic        rd_start;
  logic        mapped;
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // pin synchroniser: a change counts once stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q  <= 2'h0;
      s2_q  <= 2'h0;
      s3_q  <= 2'h0;
      lvl_q <= 2'h0;
    end
    else
    begin
      s1_q  <= {counter1_input_pin, counter0_input_pin};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
    end
  end

  // ---------------------------------------------------------------
  // timer tick at system clock over four
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= (div_q == TICK_LAST) ? '0 : div_q + 1'b1;
      tick_q <= (div_q == TICK_LAST);
    end
  end

  // ---------------------------------------------------------------
  // apb slave: one wait state, pready straight from a flop
  // ---------------------------------------------------------------
  assign access   = psel && penable;
  assign commit   = access && pready;
  assign wr       = commit && pwrite;
  assign rd_start = access && !pready && !pwrite;
  assign mapped   = hit(paddr, OFF_CTRL0) || hit(paddr, OFF_CTRL1) || hit(paddr, OFF_CNT0)
                    || hit(paddr, OFF_CNT1_LO) || hit(paddr, OFF_CNT1_HI)
                    || hit(paddr, OFF_INTC) || hit(paddr, OFF_PORT);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit(paddr, OFF_CTRL0))   rd_mux[7:0] = ctrl0_q;
    if (hit(paddr, OFF_CTRL1))   rd_mux[7:0] = ctrl1_q;
    if (hit(paddr, OFF_CNT0))    rd_mux[7:0] = count0;
    if (hit(paddr, OFF_CNT1_LO)) rd_mux[7:0] = lo_rbuf_q;
    if (hit(paddr, OFF_CNT1_HI)) rd_mux[7:0] = count1[15:8];
    if (hit(paddr, OFF_INTC))
    begin
      rd_mux[IE0_BIT]   = ie0_q;
      rd_mux[IE1_BIT]   = ie1_q;
      rd_mux[FLAG0_BIT] = flag0_q;
      rd_mux[FLAG1_BIT] = flag1_q;
    end
    if (hit(paddr, OFF_PORT))    rd_mux[1:0] = port_in_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !mapped;
      if (rd_start)
        prdata <= rd_mux;
    end
  end

  // low byte buffers of the 16-bit counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_wbuf_q <= 8'h00;
      lo_rbuf_q <= 8'h00;
    end
    else
    begin
      if (wr && hit(paddr, OFF_CNT1_LO))
        lo_wbuf_q <= pwdata[7:0];
      if (rd_start && hit(paddr, OFF_CNT1_HI))
        lo_rbuf_q <= count1[7:0];
    end
  end

  // ---------------------------------------------------------------
  // control registers; a software write wins over the hardware clear
  // so a new measurement is never lost
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl0_q <= CTRL_RST;
      ctrl1_q <= CTRL_RST;
    end
    else
    begin
      if (wr && hit(paddr, OFF_CTRL0))
        ctrl0_q <= pwdata[7:0] & CTRL_MASK;
      else if (clr0 && ctrl0_q[MODE_LSB+1:MODE_LSB] == MODE_PULSE)
        ctrl0_q[RUN_BIT] <= 1'b0;
      if (wr && hit(paddr, OFF_CTRL1))
        ctrl1_q <= pwdata[7:0] & CTRL_MASK;
      else if (clr1 && ctrl1_q[MODE_LSB+1:MODE_LSB] == MODE_PULSE)
        ctrl1_q[RUN_BIT] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // request flags, enables, port control; overflow beats a clear
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ie0_q     <= 1'b0;
      ie1_q     <= 1'b0;
      flag0_q   <= 1'b0;
      flag1_q   <= 1'b0;
      port_in_q <= PORT_RST;
    end
    else
    begin
      if (wr && hit(paddr, OFF_INTC))
      begin
        ie0_q   <= pwdata[IE0_BIT];
        ie1_q   <= pwdata[IE1_BIT];
        flag0_q <= pwdata[FLAG0_BIT];
        flag1_q <= pwdata[FLAG1_BIT];
      end
      if (ovf0)
        flag0_q <= 1'b1;
      if (ovf1)
        flag1_q <= 1'b1;
      if (wr && hit(paddr, OFF_PORT))
        port_in_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_irq0 <= 1'b0;
      timer_irq1 <= 1'b0;
      wake_pulse <= 1'b0;
      pullup_en  <= 2'h0;
    end
    else
    begin
      timer_irq0 <= flag0_q && ie0_q;
      timer_irq1 <= flag1_q && ie1_q;
      // a flag already set masks the wake-up
      wake_pulse <= power_down && ((ovf0 && !flag0_q) || (ovf1 && !flag1_q));
      pullup_en  <= pullup_option;
    end
  end

  // ---------------------------------------------------------------
  // counters; reads and preload writes hold the count for the access
  // ---------------------------------------------------------------
  tpc_counter_unit #(.WIDTH(8)) u_cnt0 (
    .pclk        (pclk),
    .presetn     (presetn),
    .tick        (tick_q),
    .mode        (ctrl0_q[MODE_LSB+1:MODE_LSB]),
    .run_en      (ctrl0_q[RUN_BIT]),
    .edge_sel    (ctrl0_q[EDGE_BIT]),
    .pin_lvl     (lvl_q[0]),
    .pin_ok      (pin_is_timer(ctrl0_q[MODE_LSB+1:MODE_LSB], port_in_q[0])),
    .inhibit     (access && hit(paddr, OFF_CNT0)),
    .preload_we  (wr && hit(paddr, OFF_CNT0)),
    .preload_val (pwdata[7:0]),
    .count_q     (count0),
    .run_clear_q (clr0),
    .overflow_q  (ovf0)
  );

  tpc_counter_unit #(.WIDTH(16)) u_cnt1 (
    .pclk        (pclk),
    .presetn     (presetn),
    .tick        (tick_q),
    .mode        (ctrl1_q[MODE_LSB+1:MODE_LSB]),
    .run_en      (ctrl1_q[RUN_BIT]),
    .edge_sel    (ctrl1_q[EDGE_BIT]),
    .pin_lvl     (lvl_q[1]),
    .pin_ok      (pin_is_timer(ctrl1_q[MODE_LSB+1:MODE_LSB], port_in_q[1])),
    .inhibit     (access && (hit(paddr, OFF_CNT1_LO) || hit(paddr, OFF_CNT1_HI))),
    .preload_we  (wr && hit(paddr, OFF_CNT1_HI)),
    .preload_val ({pwdata[7:0], lo_wbuf_q}),
    .count_q     (count1),
    .run_clear_q (clr1),
    .overflow_q  (ovf1)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    ovf0 |=> flag0_q ##1 (timer_irq0 == ie0_q || $changed(ie0_q)))
    else $error("overflow did not set flag and request");
  AST_IRQ_MASKED: assert property (@(posedge pclk) disable iff (!presetn)
    !ie1_q |=> !timer_irq1)
    else $error("interrupt raised while disabled");
  AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    (power_down && ((ovf0 && !flag0_q) || (ovf1 && !flag1_q))) |=> wake_pulse)
    else $error("overflow in power-down did not wake");
  AST_RUN_SW_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl0_q[MODE_LSB+1:MODE_LSB] != MODE_PULSE && ctrl0_q[RUN_BIT]
     && !(wr && hit(paddr, OFF_CTRL0))) |=> ctrl0_q[RUN_BIT])
    else $error("run bit dropped outside pulse mode");
  AST_HI_COMMIT: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, OFF_CNT1_HI) && !ctrl1_q[RUN_BIT])
    |=> count1 == {$past(pwdata[7:0]), $past(lo_wbuf_q)})
    else $error("high byte write did not commit buffered low byte");

endmodule
`default_nettype wire

/* File: design/tpc_pkg.sv */
// constants and types shared by the pulse width timer/counter block
package tpc_pkg;

  // ---------------------------------------------------------------
  // bus and register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned    REG_AW      = 8;
  localparam logic [7:0]     OFF_CTRL0   = 8'h00;
  localparam logic [7:0]     OFF_CTRL1   = 8'h04;
  localparam logic [7:0]     OFF_CNT0    = 8'h08;
  localparam logic [7:0]     OFF_CNT1_LO = 8'h0C;
  localparam logic [7:0]     OFF_CNT1_HI = 8'h10;
  localparam logic [7:0]     OFF_INTC    = 8'h14;
  localparam logic [7:0]     OFF_PORT    = 8'h18;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int unsigned    MODE_LSB    = 6;
  localparam int unsigned    RUN_BIT     = 4;
  localparam int unsigned    EDGE_BIT    = 3;
  localparam logic [7:0]     CTRL_MASK   = 8'hD8;
  localparam logic [7:0]     CTRL_RST    = 8'h00;
  localparam logic [1:0]     MODE_EVENT  = 2'h1;
  localparam logic [1:0]     MODE_PULSE  = 2'h2;
  localparam logic [1:0]     MODE_TIMER  = 2'h3;

  // ---------------------------------------------------------------
  // interrupt control and port control fields
  // ---------------------------------------------------------------
  localparam int unsigned    IE0_BIT     = 0;
  localparam int unsigned    IE1_BIT     = 1;
  localparam int unsigned    FLAG0_BIT   = 2;
  localparam int unsigned    FLAG1_BIT   = 3;
  localparam logic [1:0]     PORT_RST    = 2'h0;

  // ---------------------------------------------------------------
  // timer clock divider
  // ---------------------------------------------------------------
  localparam int unsigned    SYSDIV      = 4;
  localparam int unsigned    TICK_W      = $clog2(SYSDIV);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SYSDIV - 1);

  typedef enum logic {PW_WAIT, PW_COUNT} tpc_pw_state_t;

endpackage

/* File: design/tpc_counter_unit.sv */
// one timer/event counter with pulse width measurement
`timescale 1ns/1ps
`default_nettype none
module tpc_counter_unit
  import tpc_pkg::*;
#(
  parameter int unsigned WIDTH = 8
)(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // control
  input  wire logic             tick,
  input  wire logic [1:0]       mode,
  input  wire logic             run_en,
  input  wire logic             edge_sel,
  input  wire logic             pin_lvl,
  input  wire logic             pin_ok,
  input  wire logic             inhibit,
  input  wire logic             preload_we,
  input  wire logic [WIDTH-1:0] preload_val,
  // status
  output logic [WIDTH-1:0]      count_q,
  output logic                  run_clear_q,
  output logic                  overflow_q
);

  localparam logic [WIDTH-1:0] CNT_MAX = '1;

  logic             pin_prev_q;
  logic [WIDTH-1:0] preload_q;
  tpc_pw_state_t    state_q;
  logic             pin_act;
  logic             start_edge;
  logic             ev_edge;
  logic             incr;
  logic             rise;
  logic             fall;

  // ---------------------------------------------------------------
  // edge and level decode, acted on only at timer ticks
  // ---------------------------------------------------------------
  always_comb
  begin
    rise       = pin_ok && pin_lvl && !pin_prev_q;
    fall       = pin_ok && !pin_lvl && pin_prev_q;
    start_edge = edge_sel ? rise : fall;
    ev_edge    = edge_sel ? fall : rise;
    pin_act    = pin_ok && (edge_sel ? pin_lvl : !pin_lvl);
    incr       = 1'b0;
    if (tick && run_en && !inhibit)
    begin
      unique case (mode)
        MODE_TIMER: incr = 1'b1;
        MODE_EVENT: incr = ev_edge;
        MODE_PULSE: incr = (state_q == PW_COUNT) && pin_act;
        default:    incr = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_prev_q <= 1'b0;
    else if (tick)
      pin_prev_q <= pin_lvl;
  end

  // ---------------------------------------------------------------
  // pulse measurement sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= PW_WAIT;
    else if (!run_en || mode != MODE_PULSE)
      state_q <= PW_WAIT;
    else if (tick)
    begin
      unique case (state_q)
        PW_WAIT:  if (start_edge) state_q <= PW_COUNT;
        PW_COUNT: if (!pin_act) state_q <= PW_WAIT;
      endcase
    end
  end

  // only the pulse mode ever asks for the run bit to drop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_clear_q <= 1'b0;
    else
      run_clear_q <= tick && run_en && mode == MODE_PULSE
                     && state_q == PW_COUNT && !pin_act;
  end

  // ---------------------------------------------------------------
  // count and preload
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      preload_q <= '0;
    else if (preload_we)
      preload_q <= preload_val;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= '0;
    else if (preload_we && !run_en)
      count_q <= preload_val;
    else if (incr)
      count_q <= (count_q == CNT_MAX) ? preload_q : count_q + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overflow_q <= 1'b0;
    else
      overflow_q <= incr && count_q == CNT_MAX;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_ARMED_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_PULSE && run_en && state_q == PW_WAIT && !preload_we) |=> $stable(count_q))
    else $error("count moved while armed and waiting for edge");
  AST_END_CLEARS_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && run_en && mode == MODE_PULSE && state_q == PW_COUNT && !pin_act)
    |=> run_clear_q ##1 !run_clear_q)
    else $error("pulse end did not clear run bit once");
  AST_RELOAD_ON_OVF: assert property (@(posedge pclk) disable iff (!presetn)
    (incr && count_q == CNT_MAX && !preload_we) |=> (count_q == $past(preload_q)) && overflow_q)
    else $error("overflow did not reload from preload");
  AST_INHIBIT: assert property (@(posedge pclk) disable iff (!presetn)
    (inhibit && run_en && !preload_we) |=> $stable(count_q))
    else $error("count moved while inhibited");
  AST_IDLE_IGNORES: assert property (@(posedge pclk) disable iff (!presetn)
    (!run_en) |=> state_q == PW_WAIT && !overflow_q)
    else $error("disabled counter reacted to pin");
  AST_TICK_SEEN: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == PW_COUNT && $past(state_q) == PW_WAIT) |-> $past(tick))
    else $error("pin edge recognised off a timer tick");
  AST_STOPPED_PRELOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (preload_we && !run_en) |=> count_q == $past(preload_val))
    else $error("stopped preload write missed counter");
  AST_RUN_PRELOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (preload_we && run_en) |=> $stable(count_q))
    else $error("running preload write touched counter");

endmodule
`default_nettype wire

/* File: dv/tpc_pulse_src.sv */
// external pulse source driving both timer pins
`timescale 1ns/1ps
`default_nettype none
module tpc_pulse_src
(
  // clock
  input  wire logic pclk,
  // timer pins
  output logic      pin0,
  output logic      pin1
);
  // pin0 idles high for low pulses, pin1 idles low for high pulses
  initial
  begin
    pin0 = 1'b1;
    pin1 = 1'b0;
  end

  // one pulse of cyc clocks at level lvl, then back to idle
  task automatic pulse(input bit idx, input logic lvl, input int cyc);
    @(posedge pclk);
    if (idx)
      pin1 <= lvl;
    else
      pin0 <= lvl;
    repeat (cyc) @(posedge pclk);
    if (idx)
      pin1 <= ~lvl;
    else
      pin0 <= ~lvl;
  endtask
endmodule
`default_nettype wire

/* File: dv/tpc_top_tb.sv */
// self-checking testbench for the timer/counter pair
`timescale 1ns/1ps
`default_nettype none
module tpc_top_tb
  import tpc_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pdn, last_err;
  logic [REG_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, r, m;
  logic              pready, pslverr, irq0, irq1, wake, pin0, pin1;
  logic [1:0]        pull_opt, pull_en;
  int                miscompares, comparisons, wakes;

  tpc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter0_input_pin(pin0), .counter1_input_pin(pin1),
    .pullup_option(pull_opt), .pullup_en(pull_en), .power_down(pdn),
    .timer_irq0(irq0), .timer_irq1(irq1), .wake_pulse(wake));
  tpc_pulse_src i_src (.pclk(pclk), .pin0(pin0), .pin1(pin1));

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // wake is a one-cycle pulse, so count them
  always @(posedge pclk)
    if (wake === 1'b1)
      wakes <= wakes + 1;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // idle cycle at the end keeps one assignment per signal per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  // sync and tick quantise the width, so allow a window
  task automatic rng(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    apb(1'b0, a, 32'h0);
    chk(32'(r >= lo && r <= hi), 32'h1);
  endtask

  task automatic results();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    results();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pdn = 1'b0;
    pull_opt = 2'h2;
    miscompares = 0;
    comparisons = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_CTRL0, 32'h0);
    rd(8'h1C, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    chk({30'h0, pull_en}, 32'h2);
    apb(1'b1, OFF_PORT, 32'h3);
    apb(1'b1, OFF_CNT0, 32'h0);
    apb(1'b1, OFF_CTRL0, 32'h80);
    apb(1'b1, OFF_CTRL0, 32'h90);
    repeat (40) @(posedge pclk);
    rd(OFF_CNT0, 32'h0);
    i_src.pulse(1'b0, 1'b0, 40);
    repeat (20) @(posedge pclk);
    rd(OFF_CTRL0, 32'h80);
    rng(OFF_CNT0, 32'h8, 32'hA);
    m = r;
    i_src.pulse(1'b0, 1'b0, 40);
    repeat (20) @(posedge pclk);
    rd(OFF_CNT0, m);
    // pin as output: edges must not be seen
    apb(1'b1, OFF_PORT, 32'h2);
    apb(1'b1, OFF_CTRL0, 32'h90);
    i_src.pulse(1'b0, 1'b0, 40);
    repeat (20) @(posedge pclk);
    rd(OFF_CTRL0, 32'h90);
    apb(1'b1, OFF_PORT, 32'h3);
    apb(1'b1, OFF_CTRL0, 32'h80);
    apb(1'b1, OFF_CNT0, 32'hFC);
    pdn <= 1'b1;
    apb(1'b1, OFF_CTRL0, 32'h90);
    i_src.pulse(1'b0, 1'b0, 40);
    repeat (20) @(posedge pclk);
    pdn <= 1'b0;
    chk(32'(wakes), 32'h1);
    chk({31'h0, irq0}, 32'h0);
    rd(OFF_INTC, 32'h4);
    rng(OFF_CNT0, 32'hFC, 32'hFE);
    apb(1'b1, OFF_INTC, 32'h5);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq0}, 32'h1);
    apb(1'b1, OFF_INTC, 32'h4);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq0}, 32'h0);
    // flag already set blocks wake while timer mode overflows
    pdn <= 1'b1;
    apb(1'b1, OFF_CTRL0, 32'hC0);
    apb(1'b1, OFF_CTRL0, 32'hD0);
    repeat (60) @(posedge pclk);
    rng(OFF_CNT0, 32'hFC, 32'hFF);
    rd(OFF_CTRL0, 32'hD0);
    apb(1'b1, OFF_CNT0, 32'hF0);
    repeat (20) @(posedge pclk);
    apb(1'b1, OFF_CTRL0, 32'hC0);
    chk(32'(wakes), 32'h1);
    pdn <= 1'b0;
    rng(OFF_CNT0, 32'hF0, 32'hFB);
    // event mode: one rising edge per pulse
    apb(1'b1, OFF_CNT0, 32'h0);
    apb(1'b1, OFF_CTRL0, 32'h40);
    apb(1'b1, OFF_CTRL0, 32'h50);
    i_src.pulse(1'b0, 1'b0, 40);
    repeat (20) @(posedge pclk);
    rd(OFF_CNT0, 32'h1);
    apb(1'b1, OFF_CTRL0, 32'h40);
    apb(1'b1, OFF_CNT1_LO, 32'h0);
    apb(1'b1, OFF_CNT1_HI, 32'h0);
    apb(1'b1, OFF_CTRL1, 32'h88);
    apb(1'b1, OFF_CTRL1, 32'h98);
    i_src.pulse(1'b1, 1'b1, 40);
    repeat (20) @(posedge pclk);
    rd(OFF_CTRL1, 32'h88);
    rd(OFF_CNT1_HI, 32'h0);
    rng(OFF_CNT1_LO, 32'h8, 32'hA);
    apb(1'b1, OFF_CNT1_LO, 32'h34);
    rd(OFF_CNT1_HI, 32'h0);
    apb(1'b1, OFF_CNT1_HI, 32'h12);
    rd(OFF_CNT1_HI, 32'h12);
    rd(OFF_CNT1_LO, 32'h34);
    apb(1'b1, OFF_INTC, 32'h8);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq1}, 32'h0);
    apb(1'b1, OFF_INTC, 32'hA);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq1}, 32'h1);
    pull_opt <= 2'h1;
    repeat (2) @(posedge pclk);
    chk({30'h0, pull_en}, 32'h1);
    results();
  end
endmodule
`default_nettype wire
